// [src/pfs_top.sv]
// pin function sharing: pad ownership and pad controls for six port pins
// assumes classic wishbone on clk; peripherals and pads are outside
// Operation
// - pull-up per input pin is enabled by a software bit
// - per-pin software bit selects output drive strength
// - per-pin software bit selects output slew-rate limiting
// - pin five has no slew or drive-strength setting
// - interrupt enable makes pin five the interrupt input unless reset or timer clock is enabled; own pull disable
// - reset enable makes pin five the reset input; pull-up forced
// - debug enable gives pin four to debug; pull-up forced on
// - keyboard enable plus edge bit turns pull-up into pull-down
// - comparator and converter both enabled share analog pins zero and one
`include "pfs_map.svh"
`default_nettype none

module pfs_top (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // wishbone slave
  input wire pfs_pkg::pfs_wb_req_t wb_req,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // pads (index 0..5 = port pins zero..five)
  input wire logic [5:0] pad_in,
  output pfs_pkg::pfs_pad_ctl_t [5:0] pad_ctl,
  // peripheral inputs toward pads
  input wire logic analog_comparator_out,
  input wire logic tpm_ch_out,
  input wire logic tpm_ch_oe,
  input wire logic dbg_out,
  input wire logic dbg_oe,
  // peripheral outputs from pads
  output logic irq_in,
  output logic reset_in_n,
  output logic timer_ext_clock_in,
  output logic dbg_in,
  output logic [3:0] kbd_in,
  output logic tpm_ch_in,
  output logic [3:0] adc_conn,
  output logic [1:0] analog_comparator_conn
);
  import pfs_pkg::*;

  // ************************************************************
  // registers
  // ************************************************************
  logic [5:0] data_q;
  logic [5:0] dir_q;
  logic [5:0] pull_q;
  logic [5:0] drive_q;
  logic [5:0] slew_q;
  logic [3:0] sys_q;
  logic [3:0] kbd_en_q;
  logic [3:0] kbd_edg_q;
  logic [4:0] alt_q;
  logic ack_q;
  logic [31:0] rdat_q;

  // ************************************************************
  // bus decode
  // ************************************************************
  wire logic req;
  wire logic wr;
  wire logic [31:0] rd_mux;
  wire logic [31:0] wdat;

  assign req = wb_req.cyc & wb_req.stb & ~ack_q;
  assign wr = req & wb_req.we;
  // only lane 0 carries data; narrow fields sit in the low bits
  assign wdat = wb_req.sel[0] ? wb_req.dat : 32'h0000_0000;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction : hit

  wire logic we_data = wr & wb_req.sel[0] & hit(wb_req.adr, `PFS_OFF_DATA);
  wire logic we_dir = wr & wb_req.sel[0] & hit(wb_req.adr, `PFS_OFF_DIR);
  wire logic we_pull = wr & wb_req.sel[0] & hit(wb_req.adr, `PFS_OFF_PULL);
  wire logic we_drv = wr & wb_req.sel[0] & hit(wb_req.adr, `PFS_OFF_DRIVE);
  wire logic we_slew = wr & wb_req.sel[0] & hit(wb_req.adr, `PFS_OFF_SLEW);
  wire logic we_sys = wr & wb_req.sel[0] & hit(wb_req.adr, `PFS_OFF_SYSOPT);
  wire logic we_ken = wr & wb_req.sel[0] & hit(wb_req.adr, `PFS_OFF_KBD_EN);
  wire logic we_kedg = wr & wb_req.sel[0] & hit(wb_req.adr, `PFS_OFF_KBD_EDG);
  wire logic we_alt = wr & wb_req.sel[0] & hit(wb_req.adr, `PFS_OFF_ALT);

  // ************************************************************
  // ownership per pin
  // ************************************************************
  pfs_owner_t [5:0] owner;
  wire logic irq_pe = sys_q[`PFS_SYS_IRQ_PE];
  wire logic rst_pe = sys_q[`PFS_SYS_RST_PE];
  wire logic dbg_pe = sys_q[`PFS_SYS_DBG_PE];
  wire logic timer_ext_clock_en = alt_q[`PFS_ALT_TIMER_EXT_CLOCK];
  wire logic adc_en = alt_q[`PFS_ALT_ADC];
  wire logic analog_comparator_en = alt_q[`PFS_ALT_ANALOG_COMPARATOR];

  // pin five: port, interrupt, timer clock, reset
  assign owner[5] = rst_pe ? PFS_OWN_ALT4 :
                    timer_ext_clock_en ? PFS_OWN_ALT2 :
                    irq_pe ? PFS_OWN_ALT1 : PFS_OWN_PORT;
  // pin four: port, comparator out, debug
  assign owner[4] = dbg_pe ? PFS_OWN_ALT3 :
                    alt_q[`PFS_ALT_ACMPO] ? PFS_OWN_ALT2 :
                    PFS_OWN_PORT;
  // pins three, two: port, keyboard, converter
  assign owner[3] = adc_en ? PFS_OWN_ALT2 :
                    kbd_en_q[3] ? PFS_OWN_ALT1 : PFS_OWN_PORT;
  assign owner[2] = adc_en ? PFS_OWN_ALT2 :
                    kbd_en_q[2] ? PFS_OWN_ALT1 : PFS_OWN_PORT;
  // pins one, zero: port, keyboard, analog; timer channel on pin zero only
  assign owner[1] = analog_comparator_en ? PFS_OWN_ALT4 :
                    adc_en ? PFS_OWN_ALT3 :
                    kbd_en_q[1] ? PFS_OWN_ALT1 : PFS_OWN_PORT;
  assign owner[0] = analog_comparator_en ? PFS_OWN_ALT4 :
                    adc_en ? PFS_OWN_ALT3 :
                    alt_q[`PFS_ALT_TPM] ? PFS_OWN_ALT2 :
                    kbd_en_q[0] ? PFS_OWN_ALT1 : PFS_OWN_PORT;

  // ************************************************************
  // per-pin alternate drive and pull forcing
  // ************************************************************
  logic [5:0] alt_drv;
  logic [5:0] alt_o;
  logic [5:0] alt_in_only;
  logic [5:0] frc_pull;
  logic [5:0] pull_cfg;
  logic [5:0] kbd_en6;
  logic [5:0] kbd_edg6;

  assign alt_drv[5] = 1'b0;
  assign alt_o[5] = 1'b0;
  assign alt_in_only[5] = owner[5] != PFS_OWN_PORT;
  assign frc_pull[5] = owner[5] == PFS_OWN_ALT4;
  // interrupt pull-up follows its own disable bit, not the port bit
  assign pull_cfg[5] = (owner[5] == PFS_OWN_ALT1) ?
                       ~sys_q[`PFS_SYS_IRQ_PDD] : pull_q[5];

  assign alt_drv[4] = (owner[4] == PFS_OWN_ALT3) ? dbg_oe :
                      (owner[4] == PFS_OWN_ALT2);
  assign alt_o[4] = (owner[4] == PFS_OWN_ALT3) ? dbg_out : analog_comparator_out;
  assign alt_in_only[4] = (owner[4] == PFS_OWN_ALT3) & ~dbg_oe;
  assign frc_pull[4] = owner[4] == PFS_OWN_ALT3;
  assign pull_cfg[4] = pull_q[4];

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_kbd
      wire logic analog = (owner[g] == PFS_OWN_ALT3) |
                          (owner[g] == PFS_OWN_ALT4) |
                          ((g > 1) && (owner[g] == PFS_OWN_ALT2));
      wire logic tpm_own = (g == 0) && (owner[g] == PFS_OWN_ALT2);
      assign alt_drv[g] = tpm_own & tpm_ch_oe;
      assign alt_o[g] = tpm_ch_out;
      // analog and keyboard owners are input only
      assign alt_in_only[g] = analog |
                              (owner[g] == PFS_OWN_ALT1) |
                              (tpm_own & ~tpm_ch_oe);
      assign frc_pull[g] = 1'b0;
      assign pull_cfg[g] = pull_q[g] & ~analog;
      assign kbd_en6[g] = kbd_en_q[g];
      assign kbd_edg6[g] = kbd_edg_q[g];
    end
    for (g = 0; g < 6; g++) begin : g_pad
      pfs_pad_cell u_cell (
        .port_out(data_q[g]),
        // pin five is input only: its port driver never turns on, and
        // its pull stays under software or owner control
        .port_dir(dir_q[g] & (g != 5)),
        .port_pull(g == 5 ? pull_cfg[g] : pull_cfg[g]),
        .port_drive(drive_q[g]),
        .port_slew(slew_q[g]),
        .alt_drives(alt_drv[g]),
        .alt_out(alt_o[g]),
        .alt_input_only(alt_in_only[g]),
        .force_pull(frc_pull[g]),
        .kbd_en(kbd_en6[g]),
        .kbd_edge(kbd_edg6[g]),
        .has_out_ctl(g != 5),
        .pad(pad_ctl[g])
      );
    end
  endgenerate
  assign kbd_en6[5:4] = 2'b00;
  assign kbd_edg6[5:4] = 2'b00;

  // ************************************************************
  // pad levels to peripherals
  // ************************************************************
  assign irq_in = (owner[5] == PFS_OWN_ALT1) & ~pad_in[5];
  assign reset_in_n = (owner[5] == PFS_OWN_ALT4) ? pad_in[5] : 1'b1;
  assign timer_ext_clock_in = (owner[5] == PFS_OWN_ALT2) & pad_in[5];
  assign dbg_in = (owner[4] == PFS_OWN_ALT3) ? pad_in[4] : 1'b1;
  assign kbd_in = pad_in[3:0] & kbd_en_q;
  assign tpm_ch_in = pad_in[0];
  // both analog users see pins zero and one at once, no arbitration
  assign adc_conn = {adc_en, adc_en, adc_en, adc_en};
  assign analog_comparator_conn = {analog_comparator_en, analog_comparator_en};

  // read mux; pad levels always readable at the pad offset
  assign rd_mux =
    hit(wb_req.adr, `PFS_OFF_DATA) ? {26'h0, data_q} :
    hit(wb_req.adr, `PFS_OFF_DIR) ? {26'h0, dir_q} :
    hit(wb_req.adr, `PFS_OFF_PULL) ? {26'h0, pull_q} :
    hit(wb_req.adr, `PFS_OFF_DRIVE) ? {26'h0, drive_q} :
    hit(wb_req.adr, `PFS_OFF_SLEW) ? {26'h0, slew_q} :
    hit(wb_req.adr, `PFS_OFF_SYSOPT) ? {28'h0, sys_q} :
    hit(wb_req.adr, `PFS_OFF_KBD_EN) ? {28'h0, kbd_en_q} :
    hit(wb_req.adr, `PFS_OFF_KBD_EDG) ? {28'h0, kbd_edg_q} :
    hit(wb_req.adr, `PFS_OFF_ALT) ? {27'h0, alt_q} :
    hit(wb_req.adr, `PFS_OFF_OWNER) ? {14'h0, owner} :
    hit(wb_req.adr, `PFS_OFF_PAD) ? {26'h0, pad_in} :
    32'h0000_0000;

  // ************************************************************
  // register processes
  // ************************************************************
  // bus answer: one cycle after the request, dropped the next cycle
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ack_q <= 1'b0;
      rdat_q <= 32'h0000_0000;
    end else begin
      ack_q <= req;
      rdat_q <= req ? rd_mux : rdat_q;
    end
  end

  // port registers
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      data_q <= `PFS_RST_PORT6;
      dir_q <= `PFS_RST_PORT6;
      pull_q <= `PFS_RST_PORT6;
      drive_q <= `PFS_RST_PORT6;
      slew_q <= `PFS_RST_PORT6;
    end else begin
      if (we_data) data_q <= wdat[5:0];
      if (we_dir) dir_q <= wdat[5:0];
      if (we_pull) pull_q <= wdat[5:0];
      if (we_drv) drive_q <= wdat[5:0] & 6'h1F;
      if (we_slew) slew_q <= wdat[5:0] & 6'h1F;
    end
  end

  // function enables
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sys_q <= `PFS_RST_SYSOPT;
      kbd_en_q <= `PFS_RST_KBD;
      kbd_edg_q <= `PFS_RST_KBD;
      alt_q <= `PFS_RST_ALT;
    end else begin
      if (we_sys) sys_q <= wdat[3:0];
      if (we_ken) kbd_en_q <= wdat[3:0];
      if (we_kedg) kbd_edg_q <= wdat[3:0];
      if (we_alt) alt_q <= wdat[4:0];
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;
endmodule : pfs_top

`default_nettype wire

// [pkg/pfs_map.svh]
// pin function sharing: register offsets, field positions, reset values
// assumes a 32-bit classic wishbone slave with word-aligned registers
`ifndef PFS_MAP_SVH
`define PFS_MAP_SVH

// ************************************************************
// register offsets (byte addresses)
// ************************************************************
`define PFS_OFF_DATA    8'h00
`define PFS_OFF_DIR     8'h04
`define PFS_OFF_PULL    8'h08
`define PFS_OFF_DRIVE   8'h0C
`define PFS_OFF_SLEW    8'h10
`define PFS_OFF_SYSOPT  8'h14
`define PFS_OFF_KBD_EN  8'h18
`define PFS_OFF_KBD_EDG 8'h1C
`define PFS_OFF_ALT     8'h20
`define PFS_OFF_OWNER   8'h24
`define PFS_OFF_PAD     8'h28

// ************************************************************
// field positions
// ************************************************************
`define PFS_SYS_IRQ_PE   0
`define PFS_SYS_IRQ_PDD  1
`define PFS_SYS_RST_PE   2
`define PFS_SYS_DBG_PE   3
`define PFS_ALT_TIMER_EXT_CLOCK     0
`define PFS_ALT_ACMPO    1
`define PFS_ALT_TPM      2
`define PFS_ALT_ADC      3
`define PFS_ALT_ANALOG_COMPARATOR     4

// ************************************************************
// reset values
// ************************************************************
`define PFS_RST_SYSOPT  4'h8
`define PFS_RST_PORT6   6'h00
`define PFS_RST_ALT     5'h00
`define PFS_RST_KBD     4'h0

`endif

// [pkg/pfs_pkg.sv]
// pin function sharing: shared types
// assumes the map header is included by files that need numbers
`default_nettype none

package pfs_pkg;
  // owner of a shared pin, low priority to high
  typedef enum logic [2:0] {
    PFS_OWN_PORT = 3'h0,
    PFS_OWN_ALT1 = 3'h1,
    PFS_OWN_ALT2 = 3'h2,
    PFS_OWN_ALT3 = 3'h3,
    PFS_OWN_ALT4 = 3'h4
  } pfs_owner_t;

  // pad controls toward one pad
  typedef struct packed {
    logic out;
    logic oe;
    logic pull_en;
    logic pull_down;
    logic drive_hi;
    logic slew_en;
  } pfs_pad_ctl_t;

  // wishbone request from the master
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] sel;
    logic [7:0] adr;
    logic [31:0] dat;
  } pfs_wb_req_t;
endpackage : pfs_pkg

`default_nettype wire

// [src/pfs_pad_cell.sv]
// pin function sharing: per-pad control resolution for one port pin
// assumes owner code already resolved by the parent
`default_nettype none

module pfs_pad_cell (
  // port side
  input wire logic port_out,
  input wire logic port_dir,
  input wire logic port_pull,
  input wire logic port_drive,
  input wire logic port_slew,
  // alternate side
  input wire logic alt_drives,
  input wire logic alt_out,
  input wire logic alt_input_only,
  input wire logic force_pull,
  input wire logic kbd_en,
  input wire logic kbd_edge,
  input wire logic has_out_ctl,
  // pad side
  output pfs_pkg::pfs_pad_ctl_t pad
);
  import pfs_pkg::*;

  wire logic pull_req;
  wire logic port_drv;

  // pull applies only while the pin is an input
  assign pull_req = port_pull & ~port_dir;
  assign port_drv = port_dir & ~alt_input_only & ~alt_drives;

  // combine owner and configuration into pad controls
  assign pad.out = alt_drives ? alt_out : port_out;
  assign pad.oe = port_drv | alt_drives;
  assign pad.pull_en = force_pull | pull_req;
  assign pad.pull_down = ~force_pull & kbd_en & kbd_edge & pull_req;
  assign pad.drive_hi = has_out_ctl & port_drive;
  assign pad.slew_en = has_out_ctl & port_slew;
endmodule : pfs_pad_cell

`default_nettype wire

// [sim/pfs_top_asserts.sv]
// pin function sharing: bus and pad-control checks on top ports
// assumes bind onto pfs_top; one clock, async active-low reset
`default_nettype none

module pfs_top_asserts (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // bus
  input wire pfs_pkg::pfs_wb_req_t wb_req,
  input wire logic wb_ack_o,
  // pads and peripherals
  input wire logic [5:0] pad_in,
  input wire pfs_pkg::pfs_pad_ctl_t [5:0] pad_ctl,
  input wire logic irq_in,
  input wire logic reset_in_n,
  input wire logic timer_ext_clock_in,
  input wire logic dbg_in,
  input wire logic [3:0] kbd_in
);
  import pfs_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // ************************************************************
  // helpers
  // ************************************************************
  wire logic req_w = wb_req.cyc && wb_req.stb;
  wire logic [3:0] pd_w = {pad_ctl[3].pull_down, pad_ctl[2].pull_down,
    pad_ctl[1].pull_down, pad_ctl[0].pull_down};
  wire logic [3:0] pe_w = {pad_ctl[3].pull_en, pad_ctl[2].pull_en,
    pad_ctl[1].pull_en, pad_ctl[0].pull_en};
  // ************************************************************
  // properties
  // ************************************************************
  ack_follows_a:
    assert property (req_w && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing after request");
  ack_single_a:
    assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  ack_idle_a:
    assert property (!req_w |=> !wb_ack_o)
    else $error("ack without request");
  pin_five_out_a:
    assert property (!(pad_ctl[5].oe || pad_ctl[5].drive_hi ||
      pad_ctl[5].slew_en)) else $error("pin five output control set");
  reset_pull_a:
    assert property (!reset_in_n |-> pad_ctl[5].pull_en &&
      !pad_ctl[5].pull_down) else $error("reset pin pull-up off");
  irq_owner_a:
    assert property (irq_in |-> reset_in_n && !timer_ext_clock_in && !pad_in[5])
    else $error("interrupt owner clash");
  timer_ext_clock_owner_a:
    assert property (timer_ext_clock_in |-> reset_in_n && !irq_in && pad_in[5])
    else $error("timer clock owner clash");
  debug_pull_a:
    assert property (!dbg_in |-> pad_ctl[4].pull_en &&
      !pad_ctl[4].pull_down) else $error("debug pin pull-up off");
  kbd_gate_a:
    assert property ((kbd_in & ~pad_in[3:0]) == 4'h0)
    else $error("keyboard input differs from pad");
  pull_down_a:
    assert property ((pd_w & ~pe_w) == 4'h0)
    else $error("pull-down without pull enable");
  // main scenarios seen at least once
  cover property (req_w && wb_req.we ##1 wb_ack_o);
  cover property (!reset_in_n);
  cover property (irq_in);
  cover property (pd_w != 4'h0);
endmodule : pfs_top_asserts

bind pfs_top pfs_top_asserts u_asserts (.clk(clk), .reset_n(reset_n),
  .wb_req(wb_req), .wb_ack_o(wb_ack_o), .pad_in(pad_in),
  .pad_ctl(pad_ctl), .irq_in(irq_in), .reset_in_n(reset_in_n),
  .timer_ext_clock_in(timer_ext_clock_in), .dbg_in(dbg_in), .kbd_in(kbd_in));

`default_nettype wire

// [sim/pfs_pad_model.sv]
// pin function sharing: pads and peripherals on the far side
// assumes bench sets outside drive and peripheral levels
`default_nettype none

module pfs_pad_model (
  // clock
  input wire logic clk,
  // from the block
  input wire pfs_pkg::pfs_pad_ctl_t [5:0] pad_ctl,
  // outside world
  input wire logic [5:0] ext_drv,
  input wire logic [5:0] ext_val,
  input wire logic [4:0] per_ctl,
  // toward the block
  output logic [5:0] pad_in,
  output logic analog_comparator_out,
  output logic tpm_ch_out,
  output logic tpm_ch_oe,
  output logic dbg_out,
  output logic dbg_oe
);
  import pfs_pkg::*;
  logic [5:0] float_q = 6'h15;
  // undriven, unpulled pad wanders so nothing passes by luck
  always_ff @(posedge clk) begin
    float_q <= ~float_q;
  end
  // block drive wins, then outside drive, then the pull device
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      if (pad_ctl[i].oe) pad_in[i] = pad_ctl[i].out;
      else if (ext_drv[i]) pad_in[i] = ext_val[i];
      else if (pad_ctl[i].pull_en) pad_in[i] = !pad_ctl[i].pull_down;
      else pad_in[i] = float_q[i];
    end
  end
  assign {analog_comparator_out, tpm_ch_out, tpm_ch_oe, dbg_out, dbg_oe} = per_ctl;
endmodule : pfs_pad_model

`default_nettype wire

// [sim/pfs_top_tb.sv]
// pin function sharing: self-checking bench
// assumes classic wishbone on clk, pads from pfs_pad_model
`include "pfs_map.svh"
`default_nettype none

module pfs_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import pfs_pkg::*;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  pfs_wb_req_t req = '0;
  logic [31:0] wb_dat_o, q;
  logic wb_ack_o, irq_in, reset_in_n, timer_ext_clock_in, dbg_in, tpm_ch_in;
  logic analog_comparator_out, tpm_ch_out, tpm_ch_oe, dbg_out, dbg_oe;
  logic [5:0] pad_in, ext_drv = 6'h00, ext_val = 6'h00;
  logic [4:0] per_ctl = 5'h00;
  logic [3:0] kbd_in, adc_conn;
  logic [1:0] analog_comparator_conn;
  pfs_pad_ctl_t [5:0] pad_ctl;
  int fails = 0;
  int comparisons = 0;
  always #20 clk = ~clk;
  pfs_top dut (.clk(clk), .reset_n(reset_n), .wb_req(req),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pad_in(pad_in),
    .pad_ctl(pad_ctl), .analog_comparator_out(analog_comparator_out), .tpm_ch_out(tpm_ch_out),
    .tpm_ch_oe(tpm_ch_oe), .dbg_out(dbg_out), .dbg_oe(dbg_oe),
    .irq_in(irq_in), .reset_in_n(reset_in_n), .timer_ext_clock_in(timer_ext_clock_in),
    .dbg_in(dbg_in), .kbd_in(kbd_in), .tpm_ch_in(tpm_ch_in),
    .adc_conn(adc_conn), .analog_comparator_conn(analog_comparator_conn));
  pfs_pad_model u_pads (.clk(clk), .pad_ctl(pad_ctl), .ext_drv(ext_drv),
    .ext_val(ext_val), .per_ctl(per_ctl), .pad_in(pad_in),
    .analog_comparator_out(analog_comparator_out), .tpm_ch_out(tpm_ch_out), .tpm_ch_oe(tpm_ch_oe),
    .dbg_out(dbg_out), .dbg_oe(dbg_oe));
  // ************************************************************
  // tasks
  // ************************************************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // one classic cycle; request held until the edge that samples ack high
  task automatic wb(input logic we, input logic [7:0] a,
    input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    req <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'hF, adr: a, dat: d};
    @(posedge clk);
    while (wb_ack_o !== 1'b1 && n < 40) begin
      @(posedge clk);
      n++;
    end
    if (n == 40) fails++;
    q = wb_dat_o;
    req <= '0;
  endtask : wb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb(1'b1, a, d);
  endtask : wr
  // one field of all six pad controls as a vector
  function automatic logic [31:0] pf(input int f);
    logic [31:0] v;
    v = '0;
    for (int i = 0; i < 6; i++) v[i] = pad_ctl[i][f];
    return v;
  endfunction : pf
  task automatic stop_test;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : stop_test
  // ************************************************************
  // scenarios
  // ************************************************************
  // watchdog: the sequence needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clk);
    fails++;
    stop_test;
  end
  initial begin
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    wb(0, `PFS_OFF_SYSOPT, 0); chk(q, 32'h8);
    chk(pf(3) & 32'h10, 32'h10);
    wb(0, `PFS_OFF_OWNER, 0); chk(q, 32'h3000);
    wr(`PFS_OFF_SYSOPT, 0);
    wr(`PFS_OFF_PULL, 32'h3F); chk(pf(3), 32'h3F);
    wr(`PFS_OFF_DIR, 32'h3F); wr(`PFS_OFF_DRIVE, 32'h3F);
    wr(`PFS_OFF_SLEW, 32'h2A); wr(`PFS_OFF_DATA, 32'h15);
    chk(pf(1), 32'h1F);
    chk(pf(0), 32'h0A);
    chk(pf(4), 32'h1F);
    chk(pf(5) & 32'h1F, 32'h15);
    wb(0, `PFS_OFF_DRIVE, 0); chk(q, 32'h1F);
    // keyboard edge bits flip pulls only while the pull is on
    wr(`PFS_OFF_DIR, 0); wr(`PFS_OFF_KBD_EN, 32'hF);
    wr(`PFS_OFF_KBD_EDG, 32'h5); chk(pf(2), 32'h05);
    chk(kbd_in, 32'hA);
    wr(`PFS_OFF_PULL, 0); chk(pf(2), 32'h0);
    wr(`PFS_OFF_KBD_EN, 0);
    ext_drv <= 6'h20;
    wr(`PFS_OFF_SYSOPT, 32'h1); chk(irq_in, 1);
    chk(pf(3) & 32'h20, 32'h20);
    wr(`PFS_OFF_SYSOPT, 32'h3); chk(pf(3) & 32'h20, 0);
    wb(0, `PFS_OFF_OWNER, 0); chk(q, 32'h8000);
    wr(`PFS_OFF_ALT, 32'h1); chk(irq_in, 0);
    ext_val <= 6'h20; wb(0, `PFS_OFF_PAD, 0);
    chk(q & 32'h20, 32'h20);
    chk(timer_ext_clock_in, 1);
    wr(`PFS_OFF_SYSOPT, 32'h7); chk(reset_in_n, 1);
    ext_val <= 6'h00; @(posedge clk); chk(reset_in_n, 0);
    chk(pf(3) & 32'h20, 32'h20);
    wb(0, `PFS_OFF_OWNER, 0); chk(q, 32'h20000);
    per_ctl <= 5'h01; wr(`PFS_OFF_SYSOPT, 32'h8);
    chk(pf(4) & 32'h10, 32'h10);
    chk(pf(3) & 32'h10, 32'h10);
    chk(dbg_in, 0);
    per_ctl <= 5'h0C; wr(`PFS_OFF_ALT, 32'h4);
    chk(pf(5) & pf(4) & 32'h1, 1);
    chk(tpm_ch_in, 1);
    wr(`PFS_OFF_ALT, 32'h18); chk(adc_conn, 32'hF);
    chk(analog_comparator_conn, 32'h3);
    wb(0, 8'h30, 0); chk(q, 0);
    @(posedge clk);
    reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    wb(0, `PFS_OFF_SYSOPT, 0); chk(q, 32'h8);
    stop_test;
  end
endmodule : pfs_top_tb

`default_nettype wire
